//--- swfe_pkg.sv
package swfe_pkg;

  // ---------------------------------------------------------------
  // state numbers shown on the debug output
  // ---------------------------------------------------------------
  localparam logic [2:0] ST_S0 = 3'h0;
  localparam logic [2:0] ST_S1 = 3'h1;
  localparam logic [2:0] ST_S2 = 3'h2;
  localparam logic [2:0] ST_IDLE = 3'h7;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int STATE_W = 3;
  localparam int DONE_BIT = 7;
  localparam logic [7:0] TRIG_RST = 8'h80;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ---------------------------------------------------------------
  // engine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SWFE_IDLE,
    SWFE_WR_S0,
    SWFE_WR_S1,
    SWFE_RD_S0,
    SWFE_RD_S1,
    SWFE_RD_S2
  } swfe_state_t;

endpackage

//--- swfe_byte_lane.sv
`timescale 1ns/1ns
// one 8-bit port group of the parallel data bus
module swfe_byte_lane #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic drive,
  input wire logic capture,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic pin_oe_n,
  output logic [W-1:0] captured
);

  logic [W-1:0] out_q, out_d;
  logic oe_n_q, oe_n_d;
  logic [W-1:0] cap_q, cap_d;

  always_comb begin
    out_d = load ? load_val : out_q;
    oe_n_d = ~drive;
    cap_d = capture ? pin_in : cap_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
      oe_n_q <= 1'b1;
      cap_q <= '0;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      cap_q <= cap_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
  assign captured = cap_q;

endmodule

//--- swfe_engine.sv
`timescale 1ns/1ns
// Function
// R1: write S0 drives word, asserts write enable
// R2: low byte on lines 7:0, high 15:8
// R3: write S1 branches unconditionally to idle
// R4: write sequence is 0, 1, 7
// R5: non-branching states advance sequentially to idle
// R6: read S0 asserts read enable
// R7: read S1 also asserts output enable
// R8: read S2 samples full 16-bit bus
// R9: read S2 branches unconditionally to idle
// R10: read sequence is 0, 1, 2, 7
// R11: 3-bit debug output shows current state
// R12: done flag bit 7 reports idle
// R13: low-byte write launches write, read launches read
// R14: first buffered byte goes on lines 7:0
// R15: idle keeps controls high, bus undriven
module swfe_engine (
  input wire logic clk,
  input wire logic rst_n,
  // trigger side
  input wire logic high_byte_wr,
  input wire logic [7:0] high_byte_val,
  input wire logic low_byte_wr,
  input wire logic [7:0] low_byte_val,
  input wire logic single_data_rd,
  output logic [7:0] waveform_trigger_reg,
  output logic [15:0] read_word,
  // fifo side
  output logic [7:0] low_byte_port_out,
  output logic low_byte_port_oe_n,
  input wire logic [7:0] low_byte_port_in,
  output logic [7:0] high_byte_port_out,
  output logic high_byte_port_oe_n,
  input wire logic [7:0] high_byte_port_in,
  output logic ctrl_out_zero,
  output logic ctrl_out_one,
  output logic ctrl_out_two,
  output logic [2:0] engine_state_debug
);

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  swfe_pkg::swfe_state_t st_q, st_d;
  logic [7:0] hi_q, hi_d;
  logic wen_n_q, wen_n_d;
  logic ren_n_q, ren_n_d;
  logic oe_n_q, oe_n_d;
  logic [2:0] dbg_q, dbg_d;
  logic [7:0] trig_q, trig_d;
  logic launch_wr, launch_rd;
  logic drive, capture, lo_load, hi_load;
  logic [7:0] lo_cap, hi_cap;

  // ---------------------------------------------------------------
  // launch decode
  // ---------------------------------------------------------------
  // write wins when both strobes land in one cycle
  always_comb begin
    launch_wr = 1'b0;
    launch_rd = 1'b0;
    if (st_q == swfe_pkg::SWFE_IDLE) begin
      launch_wr = low_byte_wr;
      launch_rd = single_data_rd & ~low_byte_wr;
    end
  end

  // launches while busy are dropped; the caller must poll done first
  always_comb begin
    st_d = st_q;
    lo_load = 1'b0;
    hi_load = 1'b0;
    unique case (st_q)
      swfe_pkg::SWFE_IDLE: begin
        if (launch_wr) begin // see R13
          st_d = swfe_pkg::SWFE_WR_S0;
          lo_load = 1'b1;
          hi_load = 1'b1;
        end else if (launch_rd) begin // see R13
          st_d = swfe_pkg::SWFE_RD_S0;
        end
      end
      swfe_pkg::SWFE_WR_S0: st_d = swfe_pkg::SWFE_WR_S1; // see R5
      swfe_pkg::SWFE_WR_S1: st_d = swfe_pkg::SWFE_IDLE; // see R3
      swfe_pkg::SWFE_RD_S0: st_d = swfe_pkg::SWFE_RD_S1; // see R5
      swfe_pkg::SWFE_RD_S1: st_d = swfe_pkg::SWFE_RD_S2; // see R5
      swfe_pkg::SWFE_RD_S2: st_d = swfe_pkg::SWFE_IDLE; // see R9
      // two codes are unused; fall back to idle rather than lock up
      default: st_d = swfe_pkg::SWFE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= swfe_pkg::SWFE_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // high byte holding register
  // ---------------------------------------------------------------
  // a strobe in the launch cycle still counts for that write
  always_comb begin
    hi_d = high_byte_wr ? high_byte_val : hi_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= swfe_pkg::BYTE_RST;
    end else begin
      hi_q <= hi_d;
    end
  end

  // ---------------------------------------------------------------
  // fifo controls
  // ---------------------------------------------------------------
  // outputs decoded from the next state so pins line up with debug
  always_comb begin
    wen_n_d = 1'b1; // see R15
    ren_n_d = 1'b1;
    oe_n_d = 1'b1;
    drive = 1'b0;
    capture = (st_q == swfe_pkg::SWFE_RD_S2); // see R8
    unique case (st_d)
      swfe_pkg::SWFE_WR_S0: begin
        wen_n_d = 1'b0; // see R1
        drive = 1'b1;
      end
      // data held a cycle past the write edge
      swfe_pkg::SWFE_WR_S1: drive = 1'b1;
      swfe_pkg::SWFE_RD_S0: ren_n_d = 1'b0; // see R6
      swfe_pkg::SWFE_RD_S1: begin
        ren_n_d = 1'b0;
        oe_n_d = 1'b0; // see R7
      end
      swfe_pkg::SWFE_RD_S2: begin
        ren_n_d = 1'b0;
        oe_n_d = 1'b0;
      end
      // idle: controls high, bus released
      default: drive = 1'b0; // see R15
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wen_n_q <= 1'b1;
      ren_n_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      wen_n_q <= wen_n_d;
      ren_n_q <= ren_n_d;
      oe_n_q <= oe_n_d;
    end
  end

  // ---------------------------------------------------------------
  // debug state and done flag
  // ---------------------------------------------------------------
  always_comb begin
    dbg_d = swfe_pkg::ST_IDLE;
    trig_d = 8'h00;
    unique case (st_d)
      swfe_pkg::SWFE_WR_S0: dbg_d = swfe_pkg::ST_S0; // see R4
      swfe_pkg::SWFE_WR_S1: dbg_d = swfe_pkg::ST_S1; // see R4
      swfe_pkg::SWFE_RD_S0: dbg_d = swfe_pkg::ST_S0; // see R10
      swfe_pkg::SWFE_RD_S1: dbg_d = swfe_pkg::ST_S1; // see R10
      swfe_pkg::SWFE_RD_S2: dbg_d = swfe_pkg::ST_S2; // see R10
      // idle, and the unused codes that fall back to it
      default: trig_d[swfe_pkg::DONE_BIT] = 1'b1; // see R12
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_q <= swfe_pkg::ST_IDLE;
      trig_q <= swfe_pkg::TRIG_RST;
    end else begin
      dbg_q <= dbg_d; // see R11
      trig_q <= trig_d;
    end
  end

  // ---------------------------------------------------------------
  // byte lanes
  // ---------------------------------------------------------------
  // low byte (first buffered) on lines 7:0, high on 15:8
  swfe_byte_lane #(.W(swfe_pkg::BYTE_W)) u_lo ( // see R2 see R14
    .clk(clk),
    .rst_n(rst_n),
    .load(lo_load),
    .load_val(low_byte_val),
    .drive(drive),
    .capture(capture),
    .pin_in(low_byte_port_in),
    .pin_out(low_byte_port_out),
    .pin_oe_n(low_byte_port_oe_n),
    .captured(lo_cap)
  );

  swfe_byte_lane #(.W(swfe_pkg::BYTE_W)) u_hi ( // see R2
    .clk(clk),
    .rst_n(rst_n),
    .load(hi_load),
    .load_val(hi_d),
    .drive(drive),
    .capture(capture),
    .pin_in(high_byte_port_in),
    .pin_out(high_byte_port_out),
    .pin_oe_n(high_byte_port_oe_n),
    .captured(hi_cap)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // plain registers only, so no glitch reaches the fifo pins
  assign ctrl_out_zero = wen_n_q;
  assign ctrl_out_one = ren_n_q;
  assign ctrl_out_two = oe_n_q;
  assign engine_state_debug = dbg_q;
  assign waveform_trigger_reg = trig_q;
  assign read_word = {hi_cap, lo_cap};

endmodule

//--- swfe_props.sv
`timescale 1ns/1ns
module swfe_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic low_byte_wr,
  input wire logic [7:0] low_byte_val,
  input wire logic single_data_rd,
  input wire logic [7:0] waveform_trigger_reg,
  input wire logic [7:0] low_byte_port_out,
  input wire logic low_byte_port_oe_n,
  input wire logic high_byte_port_oe_n,
  input wire logic ctrl_out_zero,
  input wire logic ctrl_out_one,
  input wire logic ctrl_out_two,
  input wire logic [2:0] engine_state_debug
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire done = waveform_trigger_reg[7];
  wire [2:0] st = engine_state_debug;
  sequence s_wr;
    st == 3'h0 && !ctrl_out_zero ##1 st == 3'h1 && ctrl_out_zero
    ##1 st == 3'h7;
  endsequence
  sequence s_rd;
    st == 3'h0 && !ctrl_out_one && ctrl_out_two
    ##1 st == 3'h1 && !ctrl_out_two ##1 st == 3'h2 && !ctrl_out_two
    ##1 st == 3'h7;
  endsequence
  wr_walk_a: assert property (low_byte_wr && done |=> s_wr)
    else $error("write state walk wrong");
  rd_walk_a: assert property (single_data_rd && !low_byte_wr && done
    |=> s_rd) else $error("read state walk wrong");
  idle_quiet_a: assert property (st == 3'h7 |-> ctrl_out_zero &&
    ctrl_out_one && ctrl_out_two && low_byte_port_oe_n &&
    high_byte_port_oe_n) else $error("idle not quiet");
  done_flag_a: assert property (waveform_trigger_reg ==
    ((st == 3'h7) ? 8'h80 : 8'h00)) else $error("done flag wrong");
  wr_drive_a: assert property (!ctrl_out_zero |->
    !low_byte_port_oe_n && !high_byte_port_oe_n) else $error("no drive");
  wr_data_a: assert property (low_byte_wr && done |=>
    low_byte_port_out == $past(low_byte_val)) else $error("low byte");
  oe_pair_a: assert property (!ctrl_out_two |-> !ctrl_out_one)
    else $error("output enable without read enable");
  rd_free_a: assert property (!ctrl_out_one |-> low_byte_port_oe_n)
    else $error("bus driven during read");
  busy_drop_a: assert property (!done &&
    (low_byte_wr || single_data_rd) |=> st != 3'h0)
    else $error("launch taken while busy");
endmodule
bind swfe_engine swfe_props i_props (.clk, .rst_n, .low_byte_wr,
  .low_byte_val, .single_data_rd, .waveform_trigger_reg,
  .low_byte_port_out, .low_byte_port_oe_n, .high_byte_port_oe_n,
  .ctrl_out_zero, .ctrl_out_one, .ctrl_out_two, .engine_state_debug);

//--- swfe_fifo_model.sv
`timescale 1ns/1ns
module swfe_fifo_model (
  input wire logic clk,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic oe_n,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] mem [$];
  logic [15:0] q = 16'h0;
  logic re_q = 1'b1;
  always @(posedge clk) begin
    re_q <= re_n;
    if (!we_n)
      mem.push_back(din);
    if (!re_n && re_q && mem.size() > 0)
      q <= mem.pop_front();
  end
  // released bus shows the inverse so a stale word never passes
  assign dout = oe_n ? ~q : q;
endmodule

//--- single_word_fifo_waveform_engine_tb.sv
`timescale 1ns/1ns
module single_word_fifo_waveform_engine_tb;
  logic clk = 0, rst_n = 0, hw = 0, lw = 0, sr = 0;
  logic [7:0] hv = 8'h00, lv = 8'h00, trig, lo_o, hi_o;
  logic lo_oe, hi_oe, c0, c1, c2;
  logic [15:0] rw, m_out;
  logic [2:0] dbg;
  int n_mismatch = 0, n_checks = 0;
  wire [7:0] lo_w = lo_oe ? m_out[7:0] : lo_o;
  wire [7:0] hi_w = hi_oe ? m_out[15:8] : hi_o;
  swfe_engine i_dut (.clk(clk), .rst_n(rst_n), .high_byte_wr(hw),
    .high_byte_val(hv), .low_byte_wr(lw), .low_byte_val(lv),
    .single_data_rd(sr), .waveform_trigger_reg(trig), .read_word(rw),
    .low_byte_port_out(lo_o), .low_byte_port_oe_n(lo_oe),
    .low_byte_port_in(lo_w), .high_byte_port_out(hi_o),
    .high_byte_port_oe_n(hi_oe), .high_byte_port_in(hi_w),
    .ctrl_out_zero(c0), .ctrl_out_one(c1), .ctrl_out_two(c2),
    .engine_state_debug(dbg));
  swfe_fifo_model i_fifo (.clk(clk), .we_n(c0), .re_n(c1), .oe_n(c2),
    .din({hi_w, lo_w}), .dout(m_out));
  initial forever #4 clk = ~clk;
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task go;
    for (int i = 0; i < 20 && trig[7] !== 1'b1; i++) @(negedge clk);
    chk("done", 16'h0001, {15'h0, trig[7]});
  endtask
  task wr(input logic [15:0] w);
    go();
    hv = w[15:8];
    hw = 1;
    lv = w[7:0];
    lw = 1;
    @(negedge clk);
    hw = 0;
    lw = 0;
    chk("lo", {8'h00, w[7:0]}, {8'h00, lo_o});
    chk("hi", {8'h00, w[15:8]}, {8'h00, hi_o});
  endtask
  task rd(input logic [15:0] w);
    go();
    sr = 1;
    @(negedge clk);
    sr = 0;
    repeat (3) @(negedge clk);
    chk("rd", w, rw);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_busy;
    wr(16'h1234);
    sr = 1;
    @(negedge clk);
    sr = 0;
    repeat (2) @(negedge clk);
    chk("dropped", 16'h0007, {13'h0, dbg});
    chk("no read", 16'h0001, {15'h0, c1});
    $display("busy test done");
  endtask
  task t_both;
    wr(16'ha5c3);
    go();
    lv = 8'h0e;
    lw = 1;
    sr = 1;
    @(negedge clk);
    lw = 0;
    sr = 0;
    chk("wr wins", 16'h0002, {14'h0, c1, c0});
    chk("held hi", 16'h00a5, {8'h0, hi_o});
    $display("both test done");
  endtask
  task t_reset;
    go();
    lv = 8'h5a;
    lw = 1;
    @(negedge clk);
    lw = 0;
    chk("launch", 16'h0000, {15'h0, c0});
    rst_n = 0;
    @(negedge clk);
    chk("rst dbg", 16'h0007, {13'h0, dbg});
    chk("rst ctl", 16'h0007, {13'h0, c2, c1, c0});
    chk("rst oe", 16'h0003, {14'h0, hi_oe, lo_oe});
    chk("rst done", 16'h0080, {8'h0, trig});
    rst_n = 1;
    $display("reset test done");
  endtask
  task t_stream;
    rd(16'h1234);
    rd(16'ha5c3);
    rd(16'ha50e);
    $display("stream test done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    t_reset();
    t_busy();
    t_both();
    t_stream();
    end_sim();
  end
  initial begin
    #2000;
    n_mismatch++;
    end_sim();
  end
endmodule
